// file: hw/sfc_device.sv
// Serial flash command interface: decoder, status register, array.
// Host drives select, serial clock and data in; array is simulated.
//
// Operation
// - All opcodes, addresses and data move most significant bit first.
// - Sampling starts at first rising clock after select falls.
// - Read data streams until the host raises select.
// - Write or erase needs select raised on a whole byte boundary.
// - Memory accesses are refused while a write or erase cycle runs.
// - Opcode 06 sets the write enable latch, status bit 1.
// - Opcode 04 clears the write enable latch.
// - Latch clears at power-up and when each write or erase completes.
// - No write or erase cycle starts while the latch is clear.
// - Opcode 05 streams the status register repeatedly.
// - Status readable while busy; bit 0 shows a cycle running.
// - Opcode 03 with three address bytes streams memory.
// - Opcode 0b with address and one dummy byte streams memory.
// - Opcode ab after three dummy bytes repeats identifier, smaller parts.
// - Opcode 9f after two dummy bytes gives identifier, largest part.
// - Opcode 01 with one data byte updates only protect bits.
// - Opcode 02 programs a page; only the last 256 bytes count.
// - Opcode c7 erases all, only when protect bits are zero.
// - Opcode d8 erases a sector; protected areas refuse erase and program.
// - Protect values 1 to 6 guard upper 1..32 sectors; 7 all.
// - Status write runs only if select rises after its eighth data bit.
// - Read address advances per byte and wraps to zero.
// - Output bits change on the falling serial clock edge.
// - Program data past page end wraps to the page start.
`default_nettype none

module sfc_device #(
    parameter int ADDR_W = 24,              // Array address bits
    parameter int SECT_W = 6,               // Sector index bits
    parameter int WS_CYC = sfc_pkg::WS_CYC, // Status write cycles
    parameter bit LARGEST = 1'b1,           // Largest family member
    parameter logic [7:0] ID_SMALL = 8'h3c, // Arbitrary value
    parameter logic [7:0] ID_LARGE = 8'hc3  // Arbitrary value
) (
    input wire logic i_core_clk,       // Core clock
    input wire logic i_reset,          // Async reset, high
    input wire logic i_core_en,        // Core clock enable
    input wire logic i_serial_clock,   // Host serial clock
    input wire logic i_chip_select_n,  // Select, active low
    input wire logic i_serial_data_in, // Serial data in
    output logic o_serial_data,        // Serial data out
    output logic o_serial_data_oe      // Data out enable
);

    ////////////////////////////////////////////////////////////////////
    // Shared state
    logic [7:0] mem [2**ADDR_W];
    logic [7:0] pbuf [256];
    logic [255:0] pvalid_q;
    sfc_pkg::sfc_state_t state_q;
    logic wel_q, busy;
    logic [2:0] prot_q, ws_prot_q;
    logic [sfc_pkg::STAT_W-1:0] status;

    ////////////////////////////////////////////////////////////////////
    // Link side: frame counters
    logic link_rst, first_q, frame_tgl_q, data_q, oe_q;
    logic byte_end, busy_l, prog_wr, rd_phase, out_act, rd_ok;
    logic [2:0] bit_q, byte_q, eff_bit, eff_byte, hdr;
    logic [7:0] sh_q, op_q, ws_byte_q, wr_ptr_q, sh_d, obyte;
    logic [23:0] addr_q, addr_full;
    logic [ADDR_W-1:0] rd_addr_q;
    logic [sfc_pkg::STAT_W-1:0] st_s1_q, st_s2_q;

    // Select high ends every frame
    assign link_rst = i_reset | i_chip_select_n;
    assign busy_l = st_s2_q[sfc_pkg::WIP_BIT];
    always_comb begin
        eff_bit = first_q ? bit_q : 3'h0;
        eff_byte = first_q ? byte_q : 3'h0;
        sh_d = {sh_q[6:0], i_serial_data_in};
        addr_full = {addr_q[15:0], sh_d};
        byte_end = (eff_bit == 3'h7);
    end
    // Array is only written while busy, and reads are gated off then
    always_comb begin
        hdr = sfc_pkg::HDR_NONE;
        rd_ok = 1'b0;
        obyte = 8'h00;
        case (op_q)
            sfc_pkg::OP_RDSR: begin
                hdr = sfc_pkg::HDR_RDSR;
                rd_ok = 1'b1;
                obyte = {3'h0, st_s2_q};
            end
            sfc_pkg::OP_READ: begin
                hdr = sfc_pkg::HDR_READ;
                rd_ok = ~busy_l;
                obyte = mem[rd_addr_q];
            end
            sfc_pkg::OP_FAST: begin
                hdr = sfc_pkg::HDR_FAST;
                rd_ok = ~busy_l;
                obyte = mem[rd_addr_q];
            end
            sfc_pkg::OP_RSID: begin
                hdr = sfc_pkg::HDR_RSID;
                rd_ok = ~LARGEST & ~busy_l;
                obyte = ID_SMALL;
            end
            sfc_pkg::OP_RDID: begin
                hdr = sfc_pkg::HDR_RDID;
                rd_ok = LARGEST & ~busy_l;
                obyte = ID_LARGE;
            end
            default: begin
                hdr = sfc_pkg::HDR_NONE;
            end
        endcase
    end
    always_comb begin
        prog_wr = (op_q == sfc_pkg::OP_PROG) && ~busy_l &&
            (eff_byte >= sfc_pkg::LEN_PROG - 3'h1);
        rd_phase = rd_ok && (eff_byte >= hdr);
        out_act = first_q && rd_ok && (byte_q >= hdr);
    end
    always_ff @(posedge i_serial_clock or posedge link_rst) begin
        if (link_rst) begin
            first_q <= 1'b0;
        end else begin
            first_q <= 1'b1;
        end
    end
    always_ff @(posedge i_serial_clock or posedge i_reset) begin
        if (i_reset) begin
            bit_q <= 3'h0;
            byte_q <= 3'h0;
            sh_q <= 8'h00;
            frame_tgl_q <= 1'b0;
        end else begin
            bit_q <= eff_bit + 3'h1;
            sh_q <= sh_d;
            if (!first_q) begin
                frame_tgl_q <= ~frame_tgl_q;
            end
            if (byte_end && eff_byte != sfc_pkg::BYTE_SAT) begin
                byte_q <= eff_byte + 3'h1;
            end else if (!first_q) begin
                byte_q <= 3'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link side: opcode, address and data capture
    always_ff @(posedge i_serial_clock or posedge i_reset) begin
        if (i_reset) begin
            op_q <= 8'h00;
            addr_q <= 24'h000000;
            ws_byte_q <= 8'h00;
            wr_ptr_q <= 8'h00;
            rd_addr_q <= '0;
        end else if (byte_end) begin
            if (eff_byte == 3'h0) begin
                op_q <= sh_d;
            end
            if (eff_byte != 3'h0 && eff_byte <= sfc_pkg::LAST_ADDR) begin
                addr_q <= addr_full;
            end
            if (eff_byte == 3'h1) begin
                ws_byte_q <= sh_d;
            end
            if (eff_byte == sfc_pkg::LAST_ADDR) begin
                wr_ptr_q <= sh_d;
                rd_addr_q <= addr_full[ADDR_W-1:0];
            end else if (prog_wr) begin
                wr_ptr_q <= wr_ptr_q + 8'h01;
            end else if (rd_phase) begin
                rd_addr_q <= rd_addr_q + ADDR_W'(1);
            end
        end
    end

    always_ff @(posedge i_serial_clock or posedge i_reset) begin
        if (i_reset) begin
            pvalid_q <= '0;
        end else if (byte_end && eff_byte == 3'h0 &&
                     sh_d == sfc_pkg::OP_PROG) begin
            pvalid_q <= '0;
        end else if (byte_end && prog_wr) begin
            pvalid_q[wr_ptr_q] <= 1'b1;
        end
    end
    // Later bytes overwrite earlier ones at the same page offset
    always_ff @(posedge i_serial_clock) begin
        if (byte_end && prog_wr) begin
            pbuf[wr_ptr_q] <= sh_d;
        end
    end
    always_ff @(posedge i_serial_clock or posedge i_reset) begin
        if (i_reset) begin
            st_s1_q <= '0;
            st_s2_q <= '0;
        end else begin
            st_s1_q <= status;
            st_s2_q <= st_s1_q;
        end
    end
    always_ff @(negedge i_serial_clock or posedge link_rst) begin
        if (link_rst) begin
            data_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            oe_q <= out_act;
            data_q <= out_act & obyte[~bit_q];
        end
    end
    assign o_serial_data = data_q;
    assign o_serial_data_oe = oe_q;
    ////////////////////////////////////////////////////////////////////
    // Core side: select sync and command commit
    logic cs_s1_q, cs_s2_q, cs_s3_q, seen_q, cs_rise, go, whole, fin;
    logic sect_prot, is_wren, is_wrdi;
    logic start_prog, start_sect, start_bulk, start_ws;
    logic [ADDR_W-1:0] idx_q, end_q;
    logic [31:0] tmr_q;
    logic [SECT_W-1:0] sect;
    logic [SECT_W:0] span;
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else if (i_core_en) begin
            cs_s1_q <= i_chip_select_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end
    // Link registers are still once select is high
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            seen_q <= 1'b0;
        end else if (i_core_en && cs_rise) begin
            seen_q <= frame_tgl_q;
        end
    end
    always_comb begin
        cs_rise = cs_s2_q & ~cs_s3_q;
        busy = (state_q != sfc_pkg::ST_IDLE);
        go = i_core_en && cs_rise && (frame_tgl_q != seen_q) && !busy;
        whole = (bit_q == 3'h0);
        sect = addr_q[ADDR_W-1 -: SECT_W];
        span = (SECT_W+1)'(1) << (prot_q - 3'h1);
        sect_prot = (prot_q == sfc_pkg::PROT_ALL) ||
            ((prot_q != sfc_pkg::PROT_NONE) && ({1'b0, ~sect} < span));
        is_wren = go && whole && op_q == sfc_pkg::OP_WREN &&
            byte_q == sfc_pkg::LEN_CMD;
        is_wrdi = go && whole && op_q == sfc_pkg::OP_WRDI &&
            byte_q == sfc_pkg::LEN_CMD;
        start_prog = go && wel_q && whole && !sect_prot &&
            op_q == sfc_pkg::OP_PROG && byte_q >= sfc_pkg::LEN_PROG;
        start_sect = go && wel_q && whole && !sect_prot &&
            op_q == sfc_pkg::OP_SECT && byte_q == sfc_pkg::LEN_ADDR;
        start_bulk = go && wel_q && whole &&
            op_q == sfc_pkg::OP_BULK && byte_q == sfc_pkg::LEN_CMD &&
            prot_q == sfc_pkg::PROT_NONE;
        start_ws = go && wel_q && whole &&
            op_q == sfc_pkg::OP_WRSR && byte_q == sfc_pkg::LEN_WRSR;
        unique case (state_q)
            sfc_pkg::ST_PROG: fin = (idx_q[7:0] == 8'hff);
            sfc_pkg::ST_ERASE: fin = (idx_q == end_q);
            sfc_pkg::ST_WSTAT: fin = (tmr_q == 32'(WS_CYC - 1));
            sfc_pkg::ST_IDLE: fin = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Core side: self-timed cycles
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= sfc_pkg::ST_IDLE;
            idx_q <= '0;
            end_q <= '0;
            tmr_q <= 32'h0000_0000;
        end else if (i_core_en) begin
            unique case (state_q)
                sfc_pkg::ST_IDLE: begin
                    if (start_prog) begin
                        state_q <= sfc_pkg::ST_PROG;
                        idx_q <= {addr_q[ADDR_W-1:8], 8'h00};
                    end else if (start_sect) begin
                        state_q <= sfc_pkg::ST_ERASE;
                        idx_q <= {sect, {(ADDR_W-SECT_W){1'b0}}};
                        end_q <= {sect, {(ADDR_W-SECT_W){1'b1}}};
                    end else if (start_bulk) begin
                        state_q <= sfc_pkg::ST_ERASE;
                        idx_q <= '0;
                        end_q <= '1;
                    end else if (start_ws) begin
                        state_q <= sfc_pkg::ST_WSTAT;
                        tmr_q <= 32'h0000_0000;
                    end
                end
                sfc_pkg::ST_PROG, sfc_pkg::ST_ERASE: begin
                    if (fin) begin
                        state_q <= sfc_pkg::ST_IDLE;
                    end else begin
                        idx_q <= idx_q + ADDR_W'(1);
                    end
                end
                sfc_pkg::ST_WSTAT: begin
                    if (fin) begin
                        state_q <= sfc_pkg::ST_IDLE;
                    end else begin
                        tmr_q <= tmr_q + 32'h0000_0001;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_core_en) begin
            if (state_q == sfc_pkg::ST_PROG && pvalid_q[idx_q[7:0]]) begin
                mem[idx_q] <= mem[idx_q] & pbuf[idx_q[7:0]];
            end else if (state_q == sfc_pkg::ST_ERASE) begin
                mem[idx_q] <= sfc_pkg::ERASED;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Core side: status register
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            wel_q <= 1'b0;
            prot_q <= sfc_pkg::PROT_RST;
            ws_prot_q <= sfc_pkg::PROT_RST;
        end else if (i_core_en) begin
            if (fin) begin
                wel_q <= 1'b0;
            end else if (is_wren) begin
                wel_q <= 1'b1;
            end else if (is_wrdi) begin
                wel_q <= 1'b0;
            end
            if (start_ws) begin
                ws_prot_q <= ws_byte_q[sfc_pkg::PROT_LSB +: sfc_pkg::PROT_W];
            end
            if (fin && state_q == sfc_pkg::ST_WSTAT) begin
                prot_q <= ws_prot_q;
            end
        end
    end

    assign status = {prot_q, wel_q, busy};

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    AST_WREN_SETS: assert property (is_wren |=> wel_q)
        else $error("write enable did not set latch");
    AST_WRDI_CLRS: assert property (is_wrdi |=> !wel_q)
        else $error("write disable did not clear latch");
    AST_DONE_CLRS: assert property (fin && i_core_en |=>
        !wel_q && state_q == sfc_pkg::ST_IDLE)
        else $error("latch not cleared at cycle end");
    AST_NO_WEL: assert property (go && !wel_q |=>
        state_q == sfc_pkg::ST_IDLE)
        else $error("cycle started without latch");
    AST_PART_BYTE: assert property (go && bit_q != 3'h0 |=>
        state_q == sfc_pkg::ST_IDLE && $stable(wel_q))
        else $error("partial byte frame acted on");
    AST_BULK_PROT: assert property (go && op_q == sfc_pkg::OP_BULK &&
        prot_q != sfc_pkg::PROT_NONE |=> state_q == sfc_pkg::ST_IDLE)
        else $error("bulk erase ran while protected");
    AST_SECT_PROT: assert property (go && sect_prot &&
        (op_q == sfc_pkg::OP_SECT || op_q == sfc_pkg::OP_PROG)
        |=> state_q == sfc_pkg::ST_IDLE)
        else $error("protected area written");
    AST_BUSY_IGN: assert property (cs_rise && busy && !fin &&
        i_core_en |=> $stable(wel_q) && $stable(prot_q))
        else $error("frame during busy changed state");
    AST_WS_PROT: assert property (start_ws ##1
        (state_q == sfc_pkg::ST_WSTAT && !fin)[*2] |->
        prot_q == $past(prot_q, 2))
        else $error("protect bits changed early");

    COV_PROG: cover property (start_prog);
    COV_BULK: cover property (start_bulk);
    COV_WSTAT: cover property (state_q == sfc_pkg::ST_WSTAT && fin);

endmodule

`default_nettype wire

// file: hw/sfc_pkg.sv
// Constants shared by the serial flash command interface.
// Assumes a 125 MHz core clock and a host-driven serial clock.
`default_nettype none

package sfc_pkg;
    // Operation codes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0b;
    localparam logic [7:0] OP_RSID = 8'hab;
    localparam logic [7:0] OP_RDID = 8'h9f;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_BULK = 8'hc7;
    localparam logic [7:0] OP_SECT = 8'hd8;

    // Bytes (opcode included) before read data starts
    localparam logic [2:0] HDR_RDSR = 3'h1;
    localparam logic [2:0] HDR_READ = 3'h4;
    localparam logic [2:0] HDR_FAST = 3'h5;
    localparam logic [2:0] HDR_RSID = 3'h4;
    localparam logic [2:0] HDR_RDID = 3'h3;
    localparam logic [2:0] HDR_NONE = 3'h7;

    // Whole-frame byte counts of write-type operations
    localparam logic [2:0] LEN_CMD = 3'h1;
    localparam logic [2:0] LEN_WRSR = 3'h2;
    localparam logic [2:0] LEN_ADDR = 3'h4;
    localparam logic [2:0] LEN_PROG = 3'h5;
    localparam logic [2:0] LAST_ADDR = 3'h3;
    localparam logic [2:0] BYTE_SAT = 3'h7;

    // Status register layout and reset values
    localparam int WIP_BIT = 0;
    localparam int WEL_BIT = 1;
    localparam int PROT_LSB = 2;
    localparam int PROT_W = 3;
    localparam int STAT_W = 5;
    localparam logic [2:0] PROT_RST = 3'h0;
    localparam logic [2:0] PROT_NONE = 3'h0;
    localparam logic [2:0] PROT_ALL = 3'h7;
    localparam logic [7:0] ERASED = 8'hff;

    // Timing
    localparam int CLK_MHZ = 125;
    localparam int T_WS_MS = 5;
    localparam int WS_CYC = T_WS_MS * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROG = 2'b01,
        ST_ERASE = 2'b10,
        ST_WSTAT = 2'b11
    } sfc_state_t;
endpackage

`default_nettype wire

// file: verification/sfc_host_model.sv
// Host side of the serial link: drives select, clock and data in.
// Assumes a device that changes its output on the falling clock edge.
`default_nettype none

module sfc_host_model (
    output logic o_serial_clock,     // Serial clock to device
    output logic o_chip_select_n,    // Select, active low
    output logic o_serial_data_in,   // Data to device
    input wire logic i_serial_data,  // Data from device
    input wire logic i_serial_data_oe // Device drive enable
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] txq[$];
    logic [8:0] rx;
    logic [1:0] rx_bit;
    event rx_ev;

    initial begin
        o_serial_clock = 1'b0;
        o_chip_select_n = 1'b1;
        o_serial_data_in = 1'b0;
        rx = 9'h000;
    end

    ////////////////////////////////////////
    // One clock pulse; device output sampled at the rising edge
    task automatic tick(input logic v);
        o_serial_data_in = v;
        #62.5;
        rx_bit = {i_serial_data_oe, i_serial_data};
        o_serial_clock = 1'b1;
        #62.5;
        o_serial_clock = 1'b0;
    endtask

    // Clock stays low outside frames
    task automatic frame(input int n_rx, input int extra);
        logic [7:0] b;
        o_chip_select_n = 1'b0;
        while (txq.size() > 0) begin
            b = txq.pop_front();
            for (int i = 7; i >= 0; i--) tick(b[i]);
        end
        for (int i = 0; i < extra; i++) tick(1'b0);
        for (int k = 0; k < n_rx; k++) begin
            for (int i = 7; i >= 0; i--) begin
                tick(~o_serial_data_in);
                rx = {rx_bit[1], rx[6:0], rx_bit[0]};
            end
            -> rx_ev;
        end
        o_chip_select_n = 1'b1;
        o_serial_data_in = ~o_serial_data_in;
        #100;
    endtask
endmodule

`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the serial flash command interface.
// Assumes the host model as link master; core clock and reset made here.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0] ID_L = 8'ha5; // Arbitrary value

    logic core_clk, reset, core_en, sclk, cs_n, sdi, sdo, sdo_oe, poll;
    logic [8:0] exp_q[$];
    logic [8:0] e;
    logic [7:0] d0, d1, d2;
    int n_mismatch = 0;
    int checks_done = 0;
    integer seed = 32'h95718f6e;

    sfc_device #(.ADDR_W(12), .WS_CYC(20), .ID_LARGE(ID_L)) DUT (
        .i_core_clk(core_clk), .i_reset(reset), .i_core_en(core_en),
        .i_serial_clock(sclk), .i_chip_select_n(cs_n),
        .i_serial_data_in(sdi), .o_serial_data(sdo),
        .o_serial_data_oe(sdo_oe));

    sfc_host_model host (.o_serial_clock(sclk), .o_chip_select_n(cs_n),
        .o_serial_data_in(sdi), .i_serial_data(sdo),
        .i_serial_data_oe(sdo_oe));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    ////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic bad(input string s);
        n_mismatch++;
        $display("MISMATCH %0t %s", $time, s);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic xs(input logic [7:0] v[$]);
        foreach (v[i]) exp_q.push_back({1'b1, v[i]});
    endtask

    task automatic send(input logic [7:0] op, input int extra, input int n);
        host.txq.push_front(op);
        host.frame(n, extra);
    endtask

    task automatic rdsr(input logic [7:0] v);
        xs({v});
        send(sfc_pkg::OP_RDSR, 0, 1);
    endtask

    task automatic rdm(input logic [23:0] a, input int n);
        host.txq = {a[23:16], a[15:8], a[7:0]};
        send(sfc_pkg::OP_READ, 0, n);
    endtask

    task automatic wren();
        send(sfc_pkg::OP_WREN, 0, 0);
    endtask

    task automatic wait_idle();
        int n;
        poll = 1'b1;
        n = 0;
        do begin
            send(sfc_pkg::OP_RDSR, 0, 1);
            n++;
        end while (host.rx[0] !== 1'b0 && n < 40);
        poll = 1'b0;
        if (host.rx[0] !== 1'b0) begin
            bad("busy never ended");
            end_sim();
        end
    endtask

    // Results are compared in arrival order against the notes
    always @(host.rx_ev) begin
        if (!poll) begin
            checks_done++;
            if (exp_q.size() == 0) begin
                bad("unexpected byte");
            end else begin
                e = exp_q.pop_front();
                if (host.rx !== e) begin
                    n_mismatch++;
                    $display("MISMATCH %0t got %h exp %h", $time, host.rx, e);
                end
            end
        end
    end

    ////////////////////////////////////////
    initial begin
        reset = 1'b1;
        core_en = 1'b0;
        poll = 1'b0;
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        core_en <= 1'b1;
        repeat (8) @(posedge core_clk);
        d0 = 8'($random(seed)) | 8'h01;
        d1 = 8'($random(seed));
        d2 = 8'($random(seed)) & 8'h7f;

        xs({8'h00, 8'h00});
        send(sfc_pkg::OP_RDSR, 0, 2);
        wren();
        rdsr(8'h02);
        send(8'h77, 0, 0);
        rdsr(8'h02);
        send(sfc_pkg::OP_WRDI, 0, 0);
        rdsr(8'h00);
        wren();
        @(posedge core_clk);
        core_en <= 1'b0;
        send(sfc_pkg::OP_WRDI, 0, 0);
        rdsr(8'h02);
        @(posedge core_clk);
        core_en <= 1'b1;
        send(sfc_pkg::OP_WRDI, 0, 0);
        rdsr(8'h00);
        done("latch");
        // Array starts unknown in simulation: erase it first
        wren();
        send(sfc_pkg::OP_BULK, 0, 0);
        wait_idle();

        host.txq = {8'h00, 8'h00, 8'hfe, 8'h00};
        send(sfc_pkg::OP_PROG, 0, 0);
        rdsr(8'h00);
        wren();
        host.txq = {8'h00, 8'h00, 8'hfe, 8'h00};
        send(sfc_pkg::OP_PROG, 3, 0);
        rdsr(8'h02);
        host.txq = {8'h00, 8'h00, 8'hfe, d0, d1, d2};
        send(sfc_pkg::OP_PROG, 0, 0);
        rdsr(8'h03);
        wait_idle();
        rdsr(8'h00);
        xs({d0, d1, 8'hff});
        rdm(24'h0000fe, 3);
        xs({8'hff, d2});
        rdm(24'h000fff, 2);
        xs({d2});
        host.txq = {8'h00, 8'h00, 8'h00, 8'h00};
        send(sfc_pkg::OP_FAST, 0, 1);
        done("program");

        wren();
        host.txq = {8'he7};
        send(sfc_pkg::OP_WRSR, 2, 0);
        rdsr(8'h02);
        host.txq = {8'he7};
        send(sfc_pkg::OP_WRSR, 0, 0);
        wait_idle();
        rdsr(8'h04);
        wren();
        host.txq = {8'h00, 8'h0f, 8'hc0};
        send(sfc_pkg::OP_SECT, 0, 0);
        host.txq = {8'h00, 8'h0f, 8'hc0, 8'h00};
        send(sfc_pkg::OP_PROG, 0, 0);
        send(sfc_pkg::OP_BULK, 0, 0);
        rdsr(8'h06);
        xs({8'hff});
        rdm(24'h000fc0, 1);
        host.txq = {8'h00, 8'h0f, 8'h80, 8'h00};
        send(sfc_pkg::OP_PROG, 0, 0);
        wait_idle();
        xs({8'h00});
        rdm(24'h000f80, 1);
        wren();
        host.txq = {8'h00, 8'h00, 8'h00};
        send(sfc_pkg::OP_SECT, 0, 0);
        wait_idle();
        xs({8'hff});
        rdm(24'h000000, 1);
        done("protect");

        wren();
        host.txq = {8'h00};
        send(sfc_pkg::OP_WRSR, 0, 0);
        wait_idle();
        wren();
        send(sfc_pkg::OP_BULK, 0, 0);
        rdsr(8'h03);
        exp_q.push_back(9'h000);
        rdm(24'h000f80, 1);
        wait_idle();
        rdsr(8'h00);
        xs({8'hff});
        rdm(24'h000f80, 1);
        done("bulk");

        xs({ID_L, ID_L});
        host.txq = {8'h00, 8'h00};
        send(sfc_pkg::OP_RDID, 0, 2);
        exp_q.push_back(9'h000);
        host.txq = {8'h00, 8'h00, 8'h00};
        send(sfc_pkg::OP_RSID, 0, 1);
        done("ident");

        if (exp_q.size() != 0)
            bad("results missing");
        end_sim();
    end
endmodule

`default_nettype wire
